// file: stpfsm_regs.vh
`ifndef STPFSM_REGS_VH
`define STPFSM_REGS_VH

// port state encodings
`define STPFSM_ST_BLOCK      3'h0
`define STPFSM_ST_LISTEN     3'h1
`define STPFSM_ST_LEARN      3'h2
`define STPFSM_ST_FORWARD    3'h3
`define STPFSM_ST_DISABLE    3'h4

// register byte offsets
`define STPFSM_OFF_CTRL      8'h00
`define STPFSM_OFF_PRIO      8'h04
`define STPFSM_OFF_MAC_LO    8'h08
`define STPFSM_OFF_MAC_HI    8'h0C
`define STPFSM_OFF_HELLO     8'h10
`define STPFSM_OFF_MAXAGE    8'h14
`define STPFSM_OFF_FWDDLY    8'h18
`define STPFSM_OFF_FORCE     8'h1C
`define STPFSM_OFF_STATE     8'h20
`define STPFSM_OFF_ROOT      8'h24

// ctrl fields
`define STPFSM_CTRL_EN_BIT   0

// force register fields
`define STPFSM_FORCE_PORT_LSB 0
`define STPFSM_FORCE_PORT_MSB 4
`define STPFSM_FORCE_ST_LSB   8
`define STPFSM_FORCE_ST_MSB   10

// reset values, timers in seconds
`define STPFSM_PRIO_RST      16'h8000
`define STPFSM_HELLO_RST     6'h02
`define STPFSM_MAXAGE_RST    6'h14
`define STPFSM_FWDDLY_RST    6'h0F

// legal setting ranges, seconds
`define STPFSM_HELLO_MIN     6'h01
`define STPFSM_HELLO_MAX     6'h0A
`define STPFSM_MAXAGE_MIN    6'h06
`define STPFSM_MAXAGE_MAX    6'h28
`define STPFSM_FWDDLY_MIN    6'h04
`define STPFSM_FWDDLY_MAX    6'h1E

// timing: tick period in ns and clock period in ns
`define STPFSM_TICK_NS       1000000000
`define STPFSM_CLK_NS        40
`define STPFSM_TICK_CYC      (`STPFSM_TICK_NS / `STPFSM_CLK_NS)

`endif

// file: stpfsm_tick.v
`timescale 1ns/100ps
`include "stpfsm_regs.vh"

module stpfsm_tick #(
	parameter TICK_CYC = `STPFSM_TICK_CYC
) (
	// clock and reset
	input  wire aclk,
	input  wire aresetn,
	input  wire clk_en,
	// tick out
	output reg  tick
);

	reg [31:0] count;

	// prescaler: one pulse per second
	always @(posedge aclk) begin
		if (!aresetn) begin
			count <= 32'h00000000;
			tick  <= 1'b0;
		end else if (clk_en) begin
			if (count >= TICK_CYC - 1) begin
				count <= 32'h00000000;
				tick  <= 1'b1;
			end else begin
				count <= count + 32'h00000001;
				tick  <= 1'b0;
			end
		end
	end

endmodule

// file: stpfsm_port.v
`timescale 1ns/100ps
`include "stpfsm_regs.vh"

module stpfsm_port (
	// clock and reset
	input  wire       aclk,
	input  wire       aresetn,
	input  wire       clk_en,
	// control
	input  wire       tick,
	input  wire       stp_en,
	input  wire [5:0] fwd_delay,
	input  wire [5:0] max_age,
	input  wire       bpdu_rx,
	input  wire       bpdu_block,
	input  wire       link_up,
	input  wire       force_req,
	input  wire [2:0] force_state,
	// status
	output reg  [2:0] state,
	output reg        state_chg,
	output reg        info_valid,
	output reg        age_expired
);

	reg [5:0] delay_left;
	reg [5:0] age;
	reg [2:0] next_state;

	// legal next state; forced requests only follow the legal graph
	always @* begin
		next_state = state;
		case (state)
		`STPFSM_ST_BLOCK: begin
			if (force_req && (force_state == `STPFSM_ST_LISTEN ||
					force_state == `STPFSM_ST_DISABLE))
				next_state = force_state;
			else if (!link_up)
				next_state = `STPFSM_ST_DISABLE;
			else if (stp_en && bpdu_block == 1'b0)
				next_state = `STPFSM_ST_LISTEN;
		end
		`STPFSM_ST_LISTEN: begin
			if (force_req && (force_state == `STPFSM_ST_LEARN ||
					force_state == `STPFSM_ST_DISABLE))
				next_state = force_state;
			else if (!link_up || bpdu_block)
				next_state = `STPFSM_ST_DISABLE;
			else if (tick && delay_left <= 6'h01)
				next_state = `STPFSM_ST_LEARN;
		end
		`STPFSM_ST_LEARN: begin
			if (force_req && (force_state == `STPFSM_ST_FORWARD ||
					force_state == `STPFSM_ST_DISABLE))
				next_state = force_state;
			else if (!link_up || bpdu_block)
				next_state = `STPFSM_ST_DISABLE;
			else if (tick && delay_left <= 6'h01)
				next_state = `STPFSM_ST_FORWARD;
		end
		`STPFSM_ST_FORWARD: begin
			if ((force_req && force_state == `STPFSM_ST_DISABLE) ||
					!link_up || bpdu_block)
				next_state = `STPFSM_ST_DISABLE;
		end
		`STPFSM_ST_DISABLE: begin
			if ((force_req && force_state == `STPFSM_ST_BLOCK) ||
					(link_up && !force_req))
				next_state = `STPFSM_ST_BLOCK;
		end
		default: next_state = `STPFSM_ST_BLOCK;
		endcase
	end

	// state register, forward-delay and bpdu age timers
	always @(posedge aclk) begin
		if (!aresetn) begin
			state       <= `STPFSM_ST_BLOCK;
			state_chg   <= 1'b0;
			delay_left  <= 6'h00;
			age         <= 6'h00;
			info_valid  <= 1'b0;
			age_expired <= 1'b0;
		end else if (clk_en) begin
			state     <= next_state;
			state_chg <= (next_state != state);
			if (next_state != state)
				delay_left <= fwd_delay;
			else if (tick && delay_left != 6'h00)
				delay_left <= delay_left - 6'h01;
			age_expired <= 1'b0;
			if (bpdu_rx) begin
				age        <= 6'h00;
				info_valid <= 1'b1;
			end else if (tick && info_valid) begin
				if (age >= max_age) begin
					info_valid  <= 1'b0;
					age_expired <= 1'b1;
				end else begin
					age <= age + 6'h01;
				end
			end
		end
	end

endmodule

// file: stpfsm_top.v
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
`include "stpfsm_regs.vh"

module stpfsm_top #(
	parameter NPORTS   = 8,
	parameter TICK_CYC = `STPFSM_TICK_CYC
) (
	// clock, reset, enable
	input  wire              aclk,
	input  wire              aresetn,
	input  wire              clk_en,
	// axi4-lite write address
	input  wire [7:0]        s_axi_awaddr,
	input  wire              s_axi_awvalid,
	output wire              s_axi_awready,
	// axi4-lite write data
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output wire              s_axi_wready,
	// axi4-lite write response
	output reg  [1:0]        s_axi_bresp,
	output reg               s_axi_bvalid,
	input  wire              s_axi_bready,
	// axi4-lite read address
	input  wire [7:0]        s_axi_araddr,
	input  wire              s_axi_arvalid,
	output wire              s_axi_arready,
	// axi4-lite read data
	output reg  [31:0]       s_axi_rdata,
	output reg  [1:0]        s_axi_rresp,
	output reg               s_axi_rvalid,
	input  wire              s_axi_rready,
	// per-port frame classification and link status
	input  wire [NPORTS-1:0] bpdu_rx,
	input  wire [NPORTS-1:0] bpdu_block,
	input  wire [NPORTS-1:0] root_bpdu_rx,
	input  wire [NPORTS-1:0] link_up,
	// per-port gating and state-change pulses
	output wire [NPORTS-1:0] data_rx_en,
	output wire [NPORTS-1:0] data_tx_en,
	output wire [NPORTS-1:0] learn_en,
	output wire [NPORTS-1:0] bpdu_pass_en,
	output wire [NPORTS-1:0] mgmt_only,
	output wire [NPORTS-1:0] state_chg,
	// bridge-level outputs
	output wire [63:0]       bridge_id,
	output reg               hello_tx,
	output reg               root_claim
);

	////////////////////////////////////////////////////////////////////////
	// registers

	reg              stp_en;
	reg [15:0]       bridge_prio;
	reg [47:0]       bridge_mac;
	reg [5:0]        hello_time;
	reg [5:0]        max_age;
	reg [5:0]        fwd_delay;
	reg              force_req;
	reg [4:0]        force_port;
	reg [2:0]        force_state;
	reg              aw_full;
	reg              w_full;
	reg [7:0]        aw_addr;
	reg [31:0]       w_data;
	reg [3:0]        w_strb;
	reg [5:0]        hello_left;
	reg [5:0]        root_age;
	wire             tick;
	wire [3*NPORTS-1:0] state_flat;
	wire [NPORTS-1:0]   info_valid;
	wire [NPORTS-1:0]   age_expired;
	wire [3*NPORTS+29:0] state_wide;
	wire [NPORTS+7:0]    info_wide;

	// zero padding so builds with few ports still fill the read words
	assign state_wide = {30'h0000000, state_flat};
	assign info_wide  = {8'h00, info_valid};

	// each channel is taken once and held until the response goes
	assign s_axi_awready = !aw_full && !s_axi_bvalid;
	assign s_axi_wready  = !w_full && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	assign bridge_id = {bridge_prio, bridge_mac};

	////////////////////////////////////////////////////////////////////////
	// tick prescaler

	stpfsm_tick #(
		.TICK_CYC (TICK_CYC)
	) u_tick (
		.aclk    (aclk),
		.aresetn (aresetn),
		.clk_en  (clk_en),
		.tick    (tick)
	);

	////////////////////////////////////////////////////////////////////////
	// per-port state machines and frame gating

	genvar gi;
	generate
		for (gi = 0; gi < NPORTS; gi = gi + 1) begin : g_port
			wire [2:0] st;
			wire       frc = force_req && (force_port == gi);

			stpfsm_port u_port (
				.aclk        (aclk),
				.aresetn     (aresetn),
				.clk_en      (clk_en),
				.tick        (tick),
				.stp_en      (stp_en),
				.fwd_delay   (fwd_delay),
				.max_age     (max_age),
				.bpdu_rx     (bpdu_rx[gi]),
				.bpdu_block  (bpdu_block[gi]),
				.link_up     (link_up[gi]),
				.force_req   (frc),
				.force_state (force_state),
				.state       (st),
				.state_chg   (state_chg[gi]),
				.info_valid  (info_valid[gi]),
				.age_expired (age_expired[gi])
			);
			assign state_flat[3*gi+2:3*gi] = st;
			assign data_rx_en[gi]   = (st == `STPFSM_ST_FORWARD);
			assign data_tx_en[gi]   = (st == `STPFSM_ST_FORWARD);
			assign learn_en[gi]     = (st == `STPFSM_ST_LEARN) ||
				(st == `STPFSM_ST_FORWARD);
			assign bpdu_pass_en[gi] = (st != `STPFSM_ST_DISABLE);
			assign mgmt_only[gi]    = (st == `STPFSM_ST_DISABLE);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// hello timer and root claim

	// hello period; claim root after max age silence
	always @(posedge aclk) begin
		if (!aresetn) begin
			hello_left <= `STPFSM_HELLO_RST;
			root_age   <= 6'h00;
			root_claim <= 1'b0;
			hello_tx   <= 1'b0;
		end else if (clk_en) begin
			hello_tx <= 1'b0;
			if (!stp_en) begin
				root_age   <= 6'h00;
				root_claim <= 1'b0;
			end else if (|root_bpdu_rx) begin
				root_age   <= 6'h00;
				root_claim <= 1'b0;
			end else if (tick) begin
				if (root_age >= max_age)
					root_claim <= 1'b1;
				else
					root_age <= root_age + 6'h01;
			end
			if (tick) begin
				if (hello_left <= 6'h01) begin
					hello_left <= hello_time;
					hello_tx   <= stp_en && root_claim;
				end else begin
					hello_left <= hello_left - 6'h01;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// axi4-lite write path

	wire do_write = aw_full && w_full && !s_axi_bvalid;
	wire [5:0] wv6 = w_data[5:0];

	// address and data may arrive in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_full      <= 1'b0;
			w_full       <= 1'b0;
			aw_addr      <= 8'h00;
			w_data       <= 32'h00000000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
			stp_en       <= 1'b0;
			bridge_prio  <= `STPFSM_PRIO_RST;
			bridge_mac   <= 48'h000000000000;
			hello_time   <= `STPFSM_HELLO_RST;
			max_age      <= `STPFSM_MAXAGE_RST;
			fwd_delay    <= `STPFSM_FWDDLY_RST;
			force_req    <= 1'b0;
			force_port   <= 5'h00;
			force_state  <= 3'h0;
		end else if (clk_en) begin
			force_req <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (do_write) begin
				aw_full      <= 1'b0;
				w_full       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= 2'h0;
				case (aw_addr)
				`STPFSM_OFF_CTRL:
					if (w_strb[0])
						stp_en <= w_data[`STPFSM_CTRL_EN_BIT];
				`STPFSM_OFF_PRIO: begin
					if (w_strb[0]) bridge_prio[7:0]  <= w_data[7:0];
					if (w_strb[1]) bridge_prio[15:8] <= w_data[15:8];
				end
				`STPFSM_OFF_MAC_LO:
					bridge_mac[31:0] <= w_data;
				`STPFSM_OFF_MAC_HI:
					bridge_mac[47:32] <= w_data[15:0];
				`STPFSM_OFF_HELLO:
					if (wv6 >= `STPFSM_HELLO_MIN && wv6 <= `STPFSM_HELLO_MAX &&
							w_data[31:6] == 26'h0000000)
						hello_time <= wv6;
					else
						s_axi_bresp <= 2'h2;
				`STPFSM_OFF_MAXAGE:
					if (wv6 >= `STPFSM_MAXAGE_MIN && wv6 <= `STPFSM_MAXAGE_MAX &&
							w_data[31:6] == 26'h0000000)
						max_age <= wv6;
					else
						s_axi_bresp <= 2'h2;
				`STPFSM_OFF_FWDDLY:
					if (wv6 >= `STPFSM_FWDDLY_MIN && wv6 <= `STPFSM_FWDDLY_MAX &&
							w_data[31:6] == 26'h0000000)
						fwd_delay <= wv6;
					else
						s_axi_bresp <= 2'h2;
				`STPFSM_OFF_FORCE: begin
					force_req   <= 1'b1;
					force_port  <= w_data[`STPFSM_FORCE_PORT_MSB:`STPFSM_FORCE_PORT_LSB];
					force_state <= w_data[`STPFSM_FORCE_ST_MSB:`STPFSM_FORCE_ST_LSB];
				end
				`STPFSM_OFF_STATE, `STPFSM_OFF_ROOT: ;
				default: s_axi_bresp <= 2'h3;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// axi4-lite read path

	// state register packs 3 bits per port (up to 10 ports fit)
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= 2'h0;
		end else if (clk_en) begin
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'h0;
				s_axi_rdata  <= 32'h00000000;
				case (s_axi_araddr)
				`STPFSM_OFF_CTRL:   s_axi_rdata <= {31'h00000000, stp_en};
				`STPFSM_OFF_PRIO:   s_axi_rdata <= {16'h0000, bridge_prio};
				`STPFSM_OFF_MAC_LO: s_axi_rdata <= bridge_mac[31:0];
				`STPFSM_OFF_MAC_HI: s_axi_rdata <= {16'h0000, bridge_mac[47:32]};
				`STPFSM_OFF_HELLO:  s_axi_rdata <= {26'h0000000, hello_time};
				`STPFSM_OFF_MAXAGE: s_axi_rdata <= {26'h0000000, max_age};
				`STPFSM_OFF_FWDDLY: s_axi_rdata <= {26'h0000000, fwd_delay};
				`STPFSM_OFF_FORCE:  s_axi_rdata <= 32'h00000000;
				`STPFSM_OFF_STATE:  s_axi_rdata <= {2'h0, state_wide[29:0]};
				`STPFSM_OFF_ROOT:   s_axi_rdata <= {info_wide[7:0], 23'h000000,
					root_claim};
				default:            s_axi_rresp <= 2'h3;
				endcase
			end
		end
	end

endmodule

// file: stpfsm_monitor.sv
`timescale 1ns/100ps
module stpfsm_chk #(
	parameter NPORTS   = 8,
	parameter TICK_CYC = 10
) (
	// clock and reset
	input wire              aclk,
	input wire              aresetn,
	// bus handshakes
	input wire              s_axi_awvalid,
	input wire              s_axi_awready,
	input wire              s_axi_wvalid,
	input wire              s_axi_wready,
	input wire              s_axi_bvalid,
	input wire              s_axi_arvalid,
	input wire              s_axi_arready,
	input wire              s_axi_rvalid,
	// port gates and events
	input wire [NPORTS-1:0] root_bpdu_rx,
	input wire [NPORTS-1:0] data_rx_en,
	input wire [NPORTS-1:0] data_tx_en,
	input wire [NPORTS-1:0] learn_en,
	input wire [NPORTS-1:0] bpdu_pass_en,
	input wire [NPORTS-1:0] mgmt_only,
	input wire [NPORTS-1:0] state_chg,
	input wire              hello_tx,
	input wire              root_claim
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [NPORTS-1:0] prev_learn, prev_mgmt;
	wire  [NPORTS-1:0] moved = (learn_en ^ prev_learn) | (mgmt_only ^ prev_mgmt);
	// last gates, so a port that just moved is visible
	always @(posedge aclk) begin
		prev_learn <= learn_en;
		prev_mgmt <= mgmt_only;
	end
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_quiet;
		!hello_tx [*8];
	endsequence
	////////////////////////////////////////
	a_rx_tx_same: assert property (data_rx_en == data_tx_en)
		else $error("rx and tx gates differ");
	a_fwd_learns: assert property ((data_rx_en & ~learn_en) == 0)
		else $error("forwarding port not learning");
	a_mgmt_excl: assert property (mgmt_only == ~bpdu_pass_en)
		else $error("disabled port passes bpdus");
	a_no_skip: assert property ((data_rx_en & ~$past(data_rx_en) & ~$past(learn_en)) == 0)
		else $error("forwarding entered not from learning");
	// gate change and event pulse both show in the cycle after the state edge
	a_chg_flag: assert property (moved != 0 |-> (state_chg & moved) == moved)
		else $error("state change without event");
	a_claim_drop: assert property (root_bpdu_rx != 0 |=> !root_claim)
		else $error("root claim kept after root bpdu");
	a_hello_claim: assert property (hello_tx |-> root_claim || $past(root_claim))
		else $error("hello sent without claim");
	a_hello_gap: assert property (hello_tx |=> s_quiet)
		else $error("hello pulses too close");
	a_b_after_wr: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
endmodule
bind stpfsm_top stpfsm_chk #(.NPORTS(NPORTS), .TICK_CYC(TICK_CYC)) stpfsm_chk_i (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .root_bpdu_rx, .data_rx_en, .data_tx_en,
	.learn_en, .bpdu_pass_en, .mgmt_only, .state_chg, .hello_tx, .root_claim);

// file: stpfsm_nbr.sv
`timescale 1ns/100ps
module stpfsm_nbr #(
	parameter NPORTS = 8
) (
	// clock
	input  wire               aclk,
	// what the neighbours present
	output logic [NPORTS-1:0] bpdu_rx,
	output logic [NPORTS-1:0] bpdu_block,
	output logic [NPORTS-1:0] root_bpdu_rx,
	output logic [NPORTS-1:0] link_up
);
	// links up from the start, no frames yet
	initial begin
		bpdu_rx = '0;
		bpdu_block = '0;
		root_bpdu_rx = '0;
		link_up = '1;
	end
	task send(input int p, input bit root);
		@(posedge aclk);
		bpdu_rx[p] <= 1'h1;
		root_bpdu_rx[p] <= root;
		@(posedge aclk);
		bpdu_rx <= '0;
		root_bpdu_rx <= '0;
	endtask
	// bpdu telling the port to stand back, held as a level
	task block(input int p, input bit v);
		@(posedge aclk);
		bpdu_block[p] <= v;
	endtask
endmodule

// file: test_spanning_tree_port_state_fsm.sv
`timescale 1ns/100ps
module test_spanning_tree_port_state_fsm;
	localparam N = 4;
	localparam T = 10;
	logic         aclk, aresetn, clk_en, hello_tx, root_claim;
	logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic         s_axi_rvalid, s_axi_rready;
	logic [7:0]   s_axi_awaddr, s_axi_araddr;
	logic [31:0]  s_axi_wdata, s_axi_rdata, d;
	logic [3:0]   s_axi_wstrb;
	logic [1:0]   s_axi_bresp, s_axi_rresp, r;
	logic [N-1:0] bpdu_rx, bpdu_block, root_bpdu_rx, link_up, data_rx_en, data_tx_en;
	logic [N-1:0] learn_en, bpdu_pass_en, mgmt_only, state_chg;
	logic [63:0]  bridge_id;
	int           err_count = 0, checked = 0, cyc = 0, pulses = 0, n, p0;
	wire  [4:0]   watch = {mgmt_only[0], hello_tx, root_claim, data_rx_en[0], learn_en[0]};
	stpfsm_top #(.NPORTS(N), .TICK_CYC(T)) stpfsm_top_i (.aclk, .aresetn, .clk_en,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .bpdu_rx, .bpdu_block, .root_bpdu_rx, .link_up,
		.data_rx_en, .data_tx_en, .learn_en, .bpdu_pass_en, .mgmt_only, .state_chg,
		.bridge_id, .hello_tx, .root_claim);
	stpfsm_nbr #(.NPORTS(N)) stpfsm_nbr_i (.aclk, .bpdu_rx, .bpdu_block, .root_bpdu_rx, .link_up);
	// 25 mhz clock
	always #20 aclk = ~aclk;
	// cycle ceiling, well above the whole run; port 0 event count
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (state_chg[0]) pulses <= pulses + 1;
		if (cyc == 4000) begin
			err_count++;
			stop_test();
		end
	end
	////////////////////////////////////////
	task chk(input string s, input [63:0] e, input [63:0] g);
		checked++;
		if (g !== e) begin
			$display("BAD %s exp %0h got %0h", s, e, g);
			err_count++;
		end
	endtask
	task stop_test;
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// address and data offered together, each dropped once taken
	task wr(input [7:0] a, input [31:0] v, input [1:0] e);
		bit aw, w;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		aw = 1;
		w = 1;
		while (aw || w) begin
			@(posedge aclk);
			if (s_axi_awready) aw = 0;
			if (s_axi_wready) w = 0;
			s_axi_awvalid <= aw;
			s_axi_wvalid <= w;
		end
		while (!s_axi_bvalid) @(posedge aclk);
		s_axi_bready <= 1'h0;
		chk("bresp", e, s_axi_bresp);
	endtask
	task rd(input [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		while (!s_axi_rvalid) @(posedge aclk);
		s_axi_rready <= 1'h0;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask
	// edges until a watched flag is sampled high, capped
	task till(input int k, input int lim);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (!watch[k] && n < lim);
	endtask
	task t_reset;
		rd(8'h20);
		chk("state", 32'h0, d);
		rd(8'h04);
		chk("prio", 32'h8000, d);
		rd(8'h10);
		chk("hello", 32'h2, d);
		rd(8'h14);
		chk("maxage", 32'h14, d);
		rd(8'h18);
		chk("fwddly", 32'hF, d);
		chk("id prio", 16'h8000, bridge_id[63:48]);
		rd(8'h28);
		chk("unmapped", 2'h3, r);
	endtask
	// timer limits past each bound, and at each bound but the hello and forward-delay maximums; rejected values leave no trace
	task t_cfg;
		static logic [41:0] tab [11] = '{{8'h18, 32'h3, 2'h2}, {8'h18, 32'h1F, 2'h2},
			{8'h14, 32'h5, 2'h2}, {8'h14, 32'h29, 2'h2}, {8'h10, 32'h0, 2'h2},
			{8'h10, 32'hB, 2'h2}, {8'h30, 32'h0, 2'h3}, {8'h10, 32'h1, 2'h0},
			{8'h10, 32'h2, 2'h0}, {8'h18, 32'h4, 2'h0}, {8'h14, 32'h28, 2'h0}};
		foreach (tab[i]) wr(tab[i][41:34], tab[i][33:2], tab[i][1:0]);
		wr(8'h14, 32'h6, 2'h0);
		rd(8'h18);
		chk("fwd kept", 32'h4, d);
		wr(8'h08, 32'h89ABCDEF, 2'h0);
		wr(8'h0C, 32'h4567, 2'h0);
		wr(8'h04, 32'h1234, 2'h0);
		chk("bridge id", 64'h1234456789ABCDEF, bridge_id);
	endtask
	task t_walk;
		wr(8'h00, 32'h1, 2'h0);
		till(0, 100);
		chk("listen time", 1'h1, n >= 3 * T && n <= 4 * T + 4);
		chk("learn gate", 2'h2, {bpdu_pass_en[0], data_tx_en[0]});
		till(1, 100);
		chk("learn time", 1'h1, n >= 4 * T - 1 && n <= 4 * T + 1);
		rd(8'h20);
		chk("settled", 32'h6DB, d);
	endtask
	// ports 0 and 1 have both heard a bpdu, so both info bits stand
	task t_root;
		stpfsm_nbr_i.send(1, 1);
		stpfsm_nbr_i.send(0, 0);
		chk("claim off", 1'h0, root_claim);
		rd(8'h24);
		chk("info", 32'h3000000, d);
		till(2, 200);
		chk("claim time", 1'h1, n >= 4 * T && n <= 7 * T);
		till(3, 100);
		till(3, 100);
		chk("hello gap", 2 * T, n);
		rd(8'h24);
		chk("aged", 32'h1, d);
	endtask
	// a blocking bpdu in forwarding, then released
	task t_block;
		p0 = pulses;
		stpfsm_nbr_i.block(0, 1);
		till(4, 8);
		chk("disabled", 1'h1, n < 8);
		repeat (4) @(posedge aclk);
		rd(8'h20);
		chk("held block", 3'h0, d[2:0]);
		stpfsm_nbr_i.block(0, 0);
		// read well inside the shortest listening spell of three full ticks
		repeat (2 * T) @(posedge aclk);
		rd(8'h20);
		chk("relisten", 3'h1, d[2:0]);
		chk("events", 3, pulses - p0);
	endtask
	// port 2: illegal, legal, then skipping requests
	task t_force;
		wr(8'h1C, 32'h202, 2'h0);
		repeat (5) @(posedge aclk);
		chk("fwd kept", 1'h1, data_rx_en[2]);
		wr(8'h1C, 32'h402, 2'h0);
		repeat (2) @(posedge aclk);
		chk("forced off", 1'h0, data_rx_en[2]);
		wr(8'h1C, 32'h302, 2'h0);
		repeat (5) @(posedge aclk);
		chk("no jump", 1'h0, data_rx_en[2]);
	endtask
	// inputs at rest, reset for three edges, then the scenarios
	initial begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 50'h0;
		clk_en = 1'h1;
		s_axi_wstrb = 4'hF;
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		t_reset();
		t_cfg();
		t_walk();
		t_root();
		t_block();
		t_force();
		stop_test();
	end
endmodule
